//--- dv/breaker_wear_monitor_tb.sv
`timescale 1ns/1ps
module breaker_wear_monitor_tb;
    import cbwm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [CUR_W-1:0] phase_a_mag;
    logic [CUR_W-1:0] phase_b_mag;
    logic [CUR_W-1:0] phase_c_mag;
    logic breaker_closed;
    logic breaker_open;
    logic trip_cmd;
    logic wear_reset = 1'b0;
    logic function_block_input = 1'b0;
    logic nv_restore_valid = 1'b0;
    logic [ACC_W-1:0] nv_restore_data = '0;
    logic nv_save_valid;
    logic [ACC_W-1:0] nv_save_data;
    logic wear_alarm;
    logic rd_pend = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    int tol_q[$];
    int n_errors = 0;
    int num_checks = 0;
    logic [CUR_W-1:0] pk;
    always #25 clk = ~clk;
    cbwm_top #(.TIMEOUT_CYCLES(200)) uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .phase_a_mag, .phase_b_mag, .phase_c_mag, .breaker_closed,
        .breaker_open, .trip_cmd, .wear_reset, .function_block_input, .nv_restore_valid,
        .nv_restore_data, .nv_save_valid, .nv_save_data, .wear_alarm);
    cbwm_line_model line (.clk, .phase_a_mag, .phase_b_mag, .phase_c_mag,
        .breaker_closed, .breaker_open, .trip_cmd);
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fail(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk_rd(input logic [DATA_W-1:0] got);
        logic [DATA_W-1:0] e;
        int t;
        e = exp_q.pop_front();
        t = tol_q.pop_front();
        num_checks++;
        if (^got === 1'bx || !(got === e || (t > 0 && got + t >= e && got <= e + t)))
            fail($sformatf("read %0h want %0h", got, e));
    endtask
    task automatic chk_alarm(input logic e);
        num_checks++;
        if (wear_alarm !== e)
            fail("alarm level");
    endtask
    // Bounded wait; a save that should not come is waited out
    task automatic wait_save(input bit want);
        int n;
        n = 0;
        while (nv_save_valid !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        num_checks++;
        if ((nv_save_valid === 1'b1) != want)
            fail("wear save");
        @(posedge clk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input int t);
        exp_q.push_back(e);
        tol_q.push_back(t);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        if (rd_pend)
            chk_rd(reg_rdata);
        rd_pend <= reg_rd;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail("watchdog");
        close_out();
    end
    initial
    begin
        void'($urandom(32'h51da));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'h0, 0);
        rd(ADDR_COUNT_ONE_KA, 32'h0000C350, 0);
        rd(ADDR_COUNT_RATED, 32'h00000064, 0);
        rd(ADDR_ALARM_LIMIT, 32'h0000C350, 0);
        rd(ADDR_RATED_CURRENT, 32'h000003E8, 0);
        rd(ADDR_MIN_CURRENT, 32'h0000000A, 0);
        rd(ADDR_WEAR, 32'h0, 0);
        rd(8'h40, 32'h0, 0);
        wr(ADDR_COUNT_ONE_KA, 32'h0);
        rd(ADDR_COUNT_ONE_KA, 32'h1, 0);
        wr(ADDR_COUNT_RATED, 32'h000186A1);
        rd(ADDR_COUNT_RATED, 32'h000186A0, 0);
        wr(ADDR_RATED_CURRENT, 32'h5);
        rd(ADDR_RATED_CURRENT, 32'h000003E8, 0);
        wr(ADDR_MIN_CURRENT, 32'h63);
        rd(ADDR_MIN_CURRENT, 32'h32, 0);
        // Equal counts give exponent zero, one unit per interruption
        wr(ADDR_MIN_CURRENT, 32'hA);
        wr(ADDR_COUNT_ONE_KA, 32'h64);
        wr(ADDR_COUNT_RATED, 32'h64);
        wr(ADDR_ALARM_LIMIT, 32'h3);
        rd(ADDR_ALARM_LIMIT, 32'h3, 0);
        line.interrupt(16'h0100, 1'b0, 1'b1);
        wait_save(1'b0);
        wr(ADDR_CTRL, 32'h1);
        line.interrupt(16'h0100, 1'b0, 1'b0);
        wait_save(1'b0);
        for (int i = 1; i <= 3; i++)
        begin
            if (i == 3)
            begin
                line.interrupt(16'h0200, 1'b1, 1'b1);
                wait_save(1'b0);
                rd(ADDR_STATUS, 32'hC, 0);
            end
            pk = CUR_W'(100 + $urandom_range(1900));
            line.interrupt(pk, 1'b0, 1'b1);
            wait_save(1'b1);
            rd(ADDR_WEAR, DATA_W'(i), 0);
            rd(ADDR_LAST_PEAK, DATA_W'(pk), 0);
            chk_alarm(i == 3);
        end
        function_block_input <= 1'b1;
        repeat (4) @(posedge clk);
        chk_alarm(1'b0);
        function_block_input <= 1'b0;
        repeat (3) @(posedge clk);
        chk_alarm(1'b1);
        wear_reset <= 1'b1;
        repeat (2) @(posedge clk);
        wear_reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk_alarm(1'b0);
        rd(ADDR_WEAR, 32'h0, 0);
        nv_restore_data <= 32'h00000500;
        nv_restore_valid <= 1'b1;
        @(posedge clk);
        nv_restore_valid <= 1'b0;
        rd(ADDR_WEAR, 32'h5, 0);
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_WEAR, 32'h0, 0);
        rd(ADDR_CTRL, 32'h1, 0);
        // Ten times the 1 kA point at exponent log(500)/log(10)
        wr(ADDR_COUNT_ONE_KA, 32'h0000C350);
        line.interrupt(16'h03E8, 1'b0, 1'b1);
        wait_save(1'b1);
        rd(ADDR_WEAR, 32'h1F4, 25);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule

//--- dv/cbwm_asserts.sv
`timescale 1ns/1ps
module cbwm_asserts
    import cbwm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 200
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Currents
    input wire logic [CUR_W-1:0] phase_a_mag,
    input wire logic [CUR_W-1:0] phase_b_mag,
    input wire logic [CUR_W-1:0] phase_c_mag,
    // Breaker and commands
    input wire logic breaker_closed,
    input wire logic breaker_open,
    input wire logic trip_cmd,
    input wire logic wear_reset,
    input wire logic function_block_input,
    // Store and result
    input wire logic nv_restore_valid,
    input wire logic [ACC_W-1:0] nv_restore_data,
    input wire logic nv_save_valid,
    input wire logic [ACC_W-1:0] nv_save_data,
    input wire logic wear_alarm
);
    // Cycles since anything that may legally move the alarm
    logic [2:0] quiet_q;
    always_ff @(posedge clk)
    begin
        if (rst || reg_wr || wear_reset || function_block_input || nv_restore_valid)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence clr_held;
        wear_reset [*2];
    endsequence
    sequence blk_quiet;
        (function_block_input && !wear_reset && !reg_wr && !nv_restore_valid) [*3];
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_rd_unmapped: assert property (reg_rd && reg_addr > ADDR_LAST_PEAK |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_clr_zero: assert property (reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[31:1] == '0)
        else $error("control read shows clear bit");
    a_save_cause: assert property ($changed(nv_save_data) |->
        nv_save_valid || $past(nv_restore_valid) || $past(rst) || $past(rst, 2))
        else $error("stored wear moved without save pulse");
    a_reset_clear: assert property (clr_held |=> nv_save_data == 32'h0)
        else $error("wear not cleared by reset input");
    a_block_alarm: assert property (function_block_input |=> !wear_alarm)
        else $error("alarm shown while blocked");
    a_block_nosave: assert property (blk_quiet |=> !nv_save_valid)
        else $error("wear added while blocked");
    a_alarm_hold: assert property ($fell(wear_alarm) |-> quiet_q < 3'h4)
        else $error("alarm dropped without clear");
    a_alarm_rise: assert property ($rose(wear_alarm) |-> nv_save_valid || quiet_q < 3'h4)
        else $error("alarm rose without wear change");
endmodule

bind cbwm_top cbwm_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_a_mag, .phase_b_mag, .phase_c_mag,
    .breaker_closed, .breaker_open, .trip_cmd, .wear_reset, .function_block_input,
    .nv_restore_valid, .nv_restore_data, .nv_save_valid, .nv_save_data, .wear_alarm);

//--- dv/cbwm_line_model.sv
`timescale 1ns/1ps
module cbwm_line_model
    import cbwm_pkg::*;
(
    // Clock
    input wire logic clk,
    // Fundamental magnitudes, 0.01 kA
    output logic [CUR_W-1:0] phase_a_mag,
    output logic [CUR_W-1:0] phase_b_mag,
    output logic [CUR_W-1:0] phase_c_mag,
    // Breaker contacts and trip
    output logic breaker_closed,
    output logic breaker_open,
    output logic trip_cmd
);
    initial
    begin
        {phase_a_mag, phase_b_mag, phase_c_mag} = {3{16'h0014}};
        breaker_closed = 1'b1;
        breaker_open = 1'b0;
        trip_cmd = 1'b0;
    end
    // One interruption; slow keeps arc current so it never ends
    task automatic interrupt(input logic [CUR_W-1:0] pk, input bit slow, input bit shut);
        @(posedge clk);
        breaker_closed <= shut;
        breaker_open <= !shut;
        phase_a_mag <= pk >> 1;
        phase_b_mag <= pk >> 2;
        phase_c_mag <= pk >> 3;
        trip_cmd <= 1'b1;
        @(posedge clk);
        phase_b_mag <= pk;
        @(posedge clk);
        phase_b_mag <= CUR_W'($urandom_range(int'(pk)));
        trip_cmd <= 1'b0;
        // Second trip edge lands during tracking on purpose
        @(posedge clk);
        trip_cmd <= 1'b1;
        @(posedge clk);
        if (!slow)
            {phase_a_mag, phase_b_mag, phase_c_mag} <= {3{16'h0005}};
        // Current gone while still closed must not end the search
        repeat (2) @(posedge clk);
        breaker_closed <= 1'b0;
        breaker_open <= 1'b1;
        trip_cmd <= 1'b0;
    endtask
endmodule

//--- pkg/cbwm_pkg.sv
package cbwm_pkg;

    // Clock and abandon time for one interruption
    localparam int CLK_HZ = 20_000_000;
    localparam int TRACK_LIMIT_MS = 1000;
    localparam int TRACK_LIMIT_CYC = CLK_HZ / 1000 * TRACK_LIMIT_MS;
    localparam int CNT_W = 25;

    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SET_W = 17;
    localparam int CUR_W = 16;
    localparam int LG_W = 13;
    localparam int FRAC_W = 8;
    localparam int ACC_W = 32;
    localparam int DIV_W = 21;
    localparam int DCNT_W = 5;
    localparam int EXP_W = 20;
    localparam int PROD_W = 36;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_ONE_KA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_RATED = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_LIMIT = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_RATED_CURRENT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_MIN_CURRENT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_WEAR = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_LAST_PEAK = 8'h20;

    // Field positions
    localparam int CTRL_ENA_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ABANDON_BIT = 2;
    localparam int STAT_ACTIVE_BIT = 3;

    // Settings: counts plain, currents in 0.01 kA
    localparam logic [SET_W-1:0] COUNT_MIN = 17'h00001;
    localparam logic [SET_W-1:0] COUNT_MAX = 17'h186A0;
    localparam logic [SET_W-1:0] COUNT_ONE_KA_RST = 17'h0C350;
    localparam logic [SET_W-1:0] COUNT_RATED_RST = 17'h00064;
    localparam logic [SET_W-1:0] ALARM_LIMIT_RST = 17'h0C350;
    localparam logic [SET_W-1:0] RATED_MIN = 17'h003E8;
    localparam logic [SET_W-1:0] RATED_MAX = 17'h02710;
    localparam logic [SET_W-1:0] RATED_RST = 17'h003E8;
    localparam logic [SET_W-1:0] IMIN_MIN = 17'h0000A;
    localparam logic [SET_W-1:0] IMIN_MAX = 17'h00032;
    localparam logic [SET_W-1:0] IMIN_RST = 17'h0000A;

    // Fixed point constants, log2 in Q5.8
    localparam logic [LG_W-1:0] LOG2_HUNDRED_Q8 = 13'h06A5;
    localparam logic [FRAC_W:0] SCALE_ONE = 9'h100;
    localparam logic signed [EXP_W-1:0] EXP_MAX = 20'sh00016;
    localparam logic signed [EXP_W-1:0] EXP_MIN = -20'sh00009;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TRACK = 4'b0010,
        ST_DIV = 4'b0100,
        ST_ADD = 4'b1000
    } cbwm_state_t;

endpackage

//--- rtl/cbwm_top.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps

module cbwm_top
    import cbwm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TRACK_LIMIT_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Phase current magnitudes, 0.01 kA units
    input wire logic [CUR_W-1:0] phase_a_mag,
    input wire logic [CUR_W-1:0] phase_b_mag,
    input wire logic [CUR_W-1:0] phase_c_mag,
    // Breaker status and commands
    input wire logic breaker_closed,
    input wire logic breaker_open,
    input wire logic trip_cmd,
    input wire logic wear_reset,
    input wire logic function_block_input,
    // Non-volatile store
    input wire logic nv_restore_valid,
    input wire logic [ACC_W-1:0] nv_restore_data,
    output logic nv_save_valid,
    output logic [ACC_W-1:0] nv_save_data,
    // Result
    output logic wear_alarm
);

    function automatic logic [LG_W-1:0] log2_q8(input logic [SET_W-1:0] x);
        logic [4:0] p;
        logic [SET_W-1:0] m;
        p = 5'h00;
        for (int i = 0; i < SET_W; i++)
        begin
            if (x[i])
            begin
                p = 5'(i);
            end
        end
        m = x << (5'(SET_W - 1) - p);
        log2_q8 = {p, m[SET_W-2 -: FRAC_W]};
    endfunction

    function automatic logic [SET_W-1:0] clamp(
        input logic [SET_W-1:0] v,
        input logic [SET_W-1:0] lo,
        input logic [SET_W-1:0] hi
    );
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    cbwm_state_t state_q;
    logic ena_q;
    logic [SET_W-1:0] n1_q;
    logic [SET_W-1:0] nr_q;
    logic [SET_W-1:0] lim_q;
    logic [SET_W-1:0] ir_q;
    logic [SET_W-1:0] imin_q;
    logic [CUR_W-1:0] peak_q;
    logic [CNT_W-1:0] cnt_q;
    logic trip_prev_q;
    logic abandon_q;
    logic alarm_q;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [DIV_W-1:0] quo_q;
    logic [LG_W-1:0] rem_q;
    logic [DCNT_W-1:0] dcnt_q;

    logic active;
    logic trip_rise;
    logic start;
    logic done;
    logic timeout;
    logic clr_cmd;
    logic clear_req;
    logic [CUR_W-1:0] peak_now;
    logic [CUR_W-1:0] peak_next;
    logic [LG_W-1:0] lg_n1;
    logic [LG_W-1:0] lg_nr;
    logic [LG_W-1:0] lg_diff;
    logic [LG_W-1:0] den;
    logic [LG_W:0] rem_sh;
    logic signed [LG_W:0] lg_e;
    logic signed [PROD_W-1:0] prod;
    logic signed [EXP_W-1:0] exp_n;
    logic signed [EXP_W-1:0] exp_neg;
    logic [ACC_W-1:0] mant;
    logic [ACC_W-1:0] incr;
    logic [ACC_W:0] sum;
    logic alarm_d;

    // Blocked or switched off means no tracking at all
    assign active = ena_q & ~function_block_input;
    assign trip_rise = trip_cmd & ~trip_prev_q;
    assign start = active & trip_rise & breaker_closed;
    assign clr_cmd = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_CLR_BIT];
    assign clear_req = wear_reset | clr_cmd;

    // Largest of the three fundamental magnitudes
    always_comb
    begin
        peak_now = phase_a_mag;
        if (phase_b_mag > peak_now)
        begin
            peak_now = phase_b_mag;
        end
        if (phase_c_mag > peak_now)
        begin
            peak_now = phase_c_mag;
        end
    end

    assign peak_next = (peak_now > peak_q) ? peak_now : peak_q;
    assign done = (peak_now < imin_q[CUR_W-1:0]) && breaker_open;
    assign timeout = (cnt_q == CNT_W'(TIMEOUT_CYCLES));

    // Exponent k = log(N1/Nr) / log(Ir); a falling line is never negative
    assign lg_n1 = log2_q8(n1_q);
    assign lg_nr = log2_q8(nr_q);
    assign lg_diff = (lg_n1 > lg_nr) ? (lg_n1 - lg_nr) : '0;
    assign den = log2_q8(ir_q) - LOG2_HUNDRED_Q8;
    assign rem_sh = {rem_q, quo_q[DIV_W-1]};

    // Increment = 2^(k*log2(Imax)), mantissa linear between powers of two
    assign lg_e = $signed({1'b0, log2_q8({1'b0, peak_q})})
        - $signed({1'b0, LOG2_HUNDRED_Q8});
    assign prod = PROD_W'(lg_e * $signed({1'b0, quo_q}));
    assign exp_n = prod[PROD_W-1 -: EXP_W];
    assign exp_neg = -exp_n;
    assign mant = ACC_W'({SCALE_ONE[FRAC_W], prod[2*FRAC_W-1 -: FRAC_W]});

    always_comb
    begin
        if (exp_n > EXP_MAX)
        begin
            incr = '1;
        end
        else if (exp_n >= 0)
        begin
            incr = mant << exp_n[4:0];
        end
        else if (exp_n > EXP_MIN)
        begin
            incr = mant >> exp_neg[4:0];
        end
        else
        begin
            incr = '0;
        end
    end

    // Clear first, then add: a finishing interruption is never lost
    always_comb
    begin
        acc_d = acc_q;
        sum = '0;
        if (nv_restore_valid)
        begin
            acc_d = nv_restore_data;
        end
        if (clear_req)
        begin
            acc_d = '0;
        end
        if (state_q == ST_ADD)
        begin
            sum = {1'b0, acc_d} + {1'b0, incr};
            acc_d = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
        end
    end

    // Alarm set wins over clear; holds even if the limit is raised
    always_comb
    begin
        alarm_d = alarm_q;
        if (acc_d[ACC_W-1:FRAC_W] >= (ACC_W-FRAC_W)'(lim_q))
        begin
            alarm_d = 1'b1;
        end
        else if (clear_req)
        begin
            alarm_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
        end
        else if (!active && state_q != ST_IDLE)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= ST_TRACK;
                    end
                end
                ST_TRACK:
                begin
                    // Further trips here are simply not looked at
                    if (done)
                    begin
                        state_q <= ST_DIV;
                    end
                    else if (timeout)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DIV:
                begin
                    if (dcnt_q == '0)
                    begin
                        state_q <= ST_ADD;
                    end
                end
                ST_ADD:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Peak tracking and elapsed time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            peak_q <= '0;
            cnt_q <= '0;
            trip_prev_q <= 1'b0;
            abandon_q <= 1'b0;
        end
        else
        begin
            trip_prev_q <= trip_cmd;
            if (state_q == ST_IDLE && start)
            begin
                peak_q <= peak_now;
                cnt_q <= '0;
                abandon_q <= 1'b0;
            end
            else if (state_q == ST_TRACK && active)
            begin
                peak_q <= peak_next;
                cnt_q <= cnt_q + 1'b1;
                if (!done && timeout)
                begin
                    abandon_q <= 1'b1;
                end
            end
        end
    end

    // Restoring divider, one quotient bit per cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            quo_q <= '0;
            rem_q <= '0;
            dcnt_q <= '0;
        end
        else if (state_q == ST_TRACK)
        begin
            quo_q <= {lg_diff, FRAC_W'(0)};
            rem_q <= '0;
            dcnt_q <= DCNT_W'(DIV_W - 1);
        end
        else if (state_q == ST_DIV)
        begin
            dcnt_q <= dcnt_q - 1'b1;
            if (rem_sh >= {1'b0, den})
            begin
                rem_q <= LG_W'(rem_sh - {1'b0, den});
                quo_q <= {quo_q[DIV_W-2:0], 1'b1};
            end
            else
            begin
                rem_q <= rem_sh[LG_W-1:0];
                quo_q <= {quo_q[DIV_W-2:0], 1'b0};
            end
        end
    end

    // Wear store; the external memory is pulsed on every change except one made while nv_restore_valid is high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_q <= '0;
            nv_save_valid <= 1'b0;
            nv_save_data <= '0;
            alarm_q <= 1'b0;
            wear_alarm <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            nv_save_valid <= (acc_d != acc_q) && !nv_restore_valid;
            nv_save_data <= acc_d;
            alarm_q <= alarm_d;
            wear_alarm <= alarm_d & active;
        end
    end

    // Settings, clamped into their legal ranges
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ena_q <= 1'b0;
            n1_q <= COUNT_ONE_KA_RST;
            nr_q <= COUNT_RATED_RST;
            lim_q <= ALARM_LIMIT_RST;
            ir_q <= RATED_RST;
            imin_q <= IMIN_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CTRL: ena_q <= reg_wdata[CTRL_ENA_BIT];
                ADDR_COUNT_ONE_KA: n1_q <= clamp(reg_wdata[SET_W-1:0], COUNT_MIN, COUNT_MAX);
                ADDR_COUNT_RATED: nr_q <= clamp(reg_wdata[SET_W-1:0], COUNT_MIN, COUNT_MAX);
                ADDR_ALARM_LIMIT: lim_q <= clamp(reg_wdata[SET_W-1:0], COUNT_MIN, COUNT_MAX);
                ADDR_RATED_CURRENT: ir_q <= clamp(reg_wdata[SET_W-1:0], RATED_MIN, RATED_MAX);
                ADDR_MIN_CURRENT: imin_q <= clamp(reg_wdata[SET_W-1:0], IMIN_MIN, IMIN_MAX);
                default:
                begin
                end
            endcase
        end
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                case (reg_addr)
                    ADDR_CTRL: reg_rdata <= DATA_W'(ena_q);
                    ADDR_COUNT_ONE_KA: reg_rdata <= DATA_W'(n1_q);
                    ADDR_COUNT_RATED: reg_rdata <= DATA_W'(nr_q);
                    ADDR_ALARM_LIMIT: reg_rdata <= DATA_W'(lim_q);
                    ADDR_RATED_CURRENT: reg_rdata <= DATA_W'(ir_q);
                    ADDR_MIN_CURRENT: reg_rdata <= DATA_W'(imin_q);
                    ADDR_WEAR: reg_rdata <= DATA_W'(acc_q[ACC_W-1:FRAC_W]);
                    ADDR_STATUS:
                    begin
                        reg_rdata[STAT_ALARM_BIT] <= alarm_q;
                        reg_rdata[STAT_BUSY_BIT] <= (state_q != ST_IDLE);
                        reg_rdata[STAT_ABANDON_BIT] <= abandon_q;
                        reg_rdata[STAT_ACTIVE_BIT] <= active;
                    end
                    ADDR_LAST_PEAK: reg_rdata <= DATA_W'(peak_q);
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule
